//--- src/pmc_cfg.svh
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
`define PMC_CLK_MHZ 100
`define PMC_NLOOP 4
`define PMC_NREG 40
`define PMC_R_CTRL 6'h00
`define PMC_R_STATUS 6'h01
`define PMC_LOOP_BASE 8
`define PMC_LOOP_STRIDE 8
`define PMC_R_LCFG 0
`define PMC_R_BW 1
`define PMC_R_RAMP 2
`define PMC_R_HWIN 3
`define PMC_R_FSW 4
`define PMC_R_FREQ 5
`define PMC_R_CMD 3'h6
`define PMC_R_LSTAT 3'h7
`define PMC_CTRL_HARD 0
`define PMC_CTRL_SOFT 1
`define PMC_CMD_UP 0
`define PMC_CMD_DOWN 1
`define PMC_CMD_LIVE 2
`define PMC_CFG_FAST 0
`define PMC_CFG_PULLFAST 1
`define PMC_CFG_RAMPEXIT 2
`define PMC_CFG_EXITBW 3
`define PMC_CFG_DCO 4
`define PMC_CFG_RAMPSW 5
`define PMC_CFG_PINSTEP 6
`define PMC_CFG_MASK_LO 8
`define PMC_BW_NORM_LO 0
`define PMC_BW_FAST_LO 8
`define PMC_BW_EXIT_LO 16
`define PMC_BW_NORM_MAX 5'h15
`define PMC_BW_FAST_MIN 5'h0C
`define PMC_BW_FAST_MAX 5'h15
`define PMC_RAMP_MAX 6'h27
`define PMC_WIN_LO 0
`define PMC_DLY_LO 8
`define PMC_HIST_DEPTH 120
`define PMC_SAMPLE_MS 1000
`define PMC_RAMP_TICK_US 100
`endif

//--- src/pmc_pkg.sv
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_FREERUN = 2'b00,
    PMC_ACQUIRE = 2'b01,
    PMC_LOCKED = 2'b10,
    PMC_HOLDOVER = 2'b11
  } pmc_mode_t;
  typedef enum logic {
    PMC_INIT_LOAD = 1'b0,
    PMC_INIT_RUN = 1'b1
  } pmc_init_t;
endpackage

//--- src/pmc_sync.sv
`timescale 1ns/1ps
module pmc_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // pmc_sync

//--- src/pmc_holdover.sv
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module pmc_holdover (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sampleTick,
  input wire logic rampTick,
  input wire logic record,
  input wire logic calcStart,
  input wire logic [2:0] winLog,
  input wire logic [6:0] winDelay,
  input wire logic [23:0] sampleIn,
  input wire logic rampStart,
  input wire logic [23:0] rampFrom,
  input wire logic [23:0] rampTo,
  input wire logic [23:0] rampStep,
  output logic [23:0] holdFreq,
  output logic holdValid,
  output logic [23:0] rampFreq,
  output logic rampBusy
);
  localparam logic [6:0] LAST = 7'(`PMC_HIST_DEPTH - 1);
  localparam logic [7:0] DEPTH = 8'(`PMC_HIST_DEPTH);
  logic [23:0] hist [0:`PMC_HIST_DEPTH-1];
  logic [6:0] wrPtr;
  logic [6:0] rdPtr;
  logic [6:0] fill;
  logic [6:0] dly;
  logic [7:0] left;
  logic [7:0] startPtr;
  logic [31:0] sum;
  logic calcBusy;
  logic [23:0] rampGoal;
  logic [23:0] gap;
  //////////////////////////////////////////////////////////////////////
  // History ring
  always_ff @(posedge clock) begin
    if (record && sampleTick) begin
      hist[wrPtr] <= sampleIn;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wrPtr <= 7'h00;
      fill <= 7'h00;
    end else if (record && sampleTick) begin
      wrPtr <= (wrPtr == LAST) ? 7'h00 : wrPtr + 7'h01;
      if (fill != LAST + 7'h01) begin
        fill <= fill + 7'h01;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Window start: newest sample minus delay
  always_comb begin
    dly = (winDelay > LAST) ? LAST : winDelay;
    startPtr = {1'b0, wrPtr} + DEPTH - 8'h01 - {1'b0, dly};
    if (startPtr >= DEPTH) begin
      startPtr = startPtr - DEPTH;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      calcBusy <= 1'b0;
      holdValid <= 1'b0;
      holdFreq <= 24'h000000;
      sum <= 32'h00000000;
      left <= 8'h00;
      rdPtr <= 7'h00;
    end else if (calcStart) begin
      calcBusy <= 1'b1;
      holdValid <= 1'b0;
      sum <= 32'h00000000;
      rdPtr <= startPtr[6:0];
      left <= 8'h01 << winLog;
    end else if (calcBusy) begin
      if (left == 8'h00) begin
        holdFreq <= 24'(sum >> winLog);
        holdValid <= 1'b1;
        calcBusy <= 1'b0;
      end else begin
        sum <= sum + {8'h00, hist[rdPtr]};
        rdPtr <= (rdPtr == 7'h00) ? LAST : rdPtr - 7'h01;
        left <= left - 8'h01;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Linear frequency ramp
  assign gap = (rampGoal > rampFreq) ? rampGoal - rampFreq
                                     : rampFreq - rampGoal;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rampBusy <= 1'b0;
      rampFreq <= 24'h000000;
      rampGoal <= 24'h000000;
    end else if (rampStart) begin
      rampFreq <= rampFrom;
      rampGoal <= rampTo;
      rampBusy <= (rampFrom != rampTo);
    end else if (rampBusy && rampTick) begin
      if (gap <= rampStep) begin
        rampFreq <= rampGoal;
        rampBusy <= 1'b0;
      end else if (rampGoal > rampFreq) begin
        rampFreq <= rampFreq + rampStep;
      end else begin
        rampFreq <= rampFreq - rampStep;
      end
    end
  end
endmodule // pmc_holdover

//--- src/pmc_top.sv
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module pmc_top #(
  parameter int unsigned SAMPLE_CYCLES =
    `PMC_SAMPLE_MS * `PMC_CLK_MHZ * 1000,
  parameter int unsigned RAMP_CYCLES = `PMC_RAMP_TICK_US * `PMC_CLK_MHZ
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hardResetPinN,
  input wire logic [3:0] inputValid,
  input wire logic [3:0] lossOfLockRaw,
  input wire logic freqStepUpPin,
  input wire logic freqStepDownPin,
  input wire logic [3:0][23:0] trackFreq,
  output logic [5:0] nvmAddr,
  input wire logic [31:0] nvmRdData,
  input wire logic [7:0] busAddr,
  input wire logic [31:0] busWrData,
  input wire logic busWrite,
  input wire logic busRead,
  output logic [31:0] busRdData,
  output logic busReady,
  output logic [3:0] clockOutEnable,
  output logic [3:0] lossOfLockPinN,
  output wire logic [3:0][23:0] freqWord,
  output wire logic [3:0][4:0] bandwidthSel
);
  logic [31:0] regMem [0:`PMC_NREG-1];
  logic hardPinSync;
  logic [3:0] validSync;
  logic [3:0] lolSync;
  logic upPinSync;
  logic downPinSync;
  logic upPinLast;
  logic downPinLast;
  logic upPinEdge;
  logic downPinEdge;
  logic hardReq;
  logic softReq;
  logic sysRstN;
  pmc_pkg::pmc_init_t initState;
  logic initDone;
  logic initDoneLast;
  logic applyAll;
  logic loadWr;
  logic [5:0] loadWrIdx;
  logic [5:0] busIdx;
  logic wrEn;
  logic [31:0] rdMux;
  logic [3:0][1:0] modeBits;
  logic [31:0] sampleCnt;
  logic [31:0] rampCnt;
  logic sampleTick;
  logic rampTick;
  //////////////////////////////////////////////////////////////////////
  // Pin inputs and resets
  pmc_sync #(
    .W(11)
  ) uSync (
    .clock(clock),
    .rst_n(rst_n),
    .din({hardResetPinN, inputValid, lossOfLockRaw, freqStepUpPin,
          freqStepDownPin}),
    .dout({hardPinSync, validSync, lolSync, upPinSync, downPinSync})
  );
  assign busIdx = busAddr[7:2];
  assign wrEn = busWrite && busReady;
  assign sysRstN = rst_n && hardPinSync && !hardReq;
  assign upPinEdge = upPinSync && !upPinLast;
  assign downPinEdge = downPinSync && !downPinLast;
  assign applyAll = softReq || (initDone && !initDoneLast);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hardReq <= 1'b0;
      upPinLast <= 1'b0;
      downPinLast <= 1'b0;
    end else begin
      hardReq <= wrEn && busIdx == `PMC_R_CTRL &&
                 busWrData[`PMC_CTRL_HARD];
      upPinLast <= upPinSync;
      downPinLast <= downPinSync;
    end
  end
  always_ff @(posedge clock) begin
    if (!sysRstN) begin
      softReq <= 1'b0;
    end else begin
      softReq <= wrEn && busIdx == `PMC_R_CTRL &&
                 busWrData[`PMC_CTRL_SOFT];
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Initialization download
  always_ff @(posedge clock) begin
    if (!sysRstN) begin
      initState <= pmc_pkg::PMC_INIT_LOAD;
      initDone <= 1'b0;
      initDoneLast <= 1'b0;
      nvmAddr <= 6'h00;
      loadWr <= 1'b0;
      loadWrIdx <= 6'h00;
    end else begin
      initDoneLast <= initDone;
      case (initState)
        pmc_pkg::PMC_INIT_LOAD: begin
          loadWr <= (nvmAddr != 6'(`PMC_NREG));
          loadWrIdx <= nvmAddr;
          if (nvmAddr != 6'(`PMC_NREG)) begin
            nvmAddr <= nvmAddr + 6'h01;
          end
          if (loadWr && loadWrIdx == 6'(`PMC_NREG - 1)) begin
            initState <= pmc_pkg::PMC_INIT_RUN;
            initDone <= 1'b1;
          end
        end
        pmc_pkg::PMC_INIT_RUN: begin
          loadWr <= 1'b0;
        end
        default: begin
          initState <= pmc_pkg::PMC_INIT_LOAD;
        end
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (loadWr && !initDone) begin
      regMem[loadWrIdx] <= nvmRdData;
    end else if (wrEn && busIdx < 6'(`PMC_NREG)) begin
      regMem[busIdx] <= busWrData;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Register reads
  always_comb begin
    rdMux = 32'h00000000;
    if (busIdx == `PMC_R_STATUS) begin
      rdMux = {16'h0000, modeBits, lossOfLockPinN, 3'h0, initDone};
    end else if (busIdx >= 6'(`PMC_LOOP_BASE) &&
                 busIdx < 6'(`PMC_NREG)) begin
      if (busIdx[2:0] == `PMC_R_LSTAT) begin
        rdMux = {29'h00000000,
                 lossOfLockPinN[busIdx[4:3] - 2'h1],
                 modeBits[busIdx[4:3] - 2'h1]};
      end else if (busIdx[2:0] != `PMC_R_CMD) begin
        rdMux = regMem[busIdx];
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!sysRstN) begin
      busRdData <= 32'h00000000;
      busReady <= 1'b0;
      clockOutEnable <= 4'h0;
    end else begin
      busRdData <= (busRead && busReady) ? rdMux : 32'h00000000;
      busReady <= initDone;
      clockOutEnable <= {4{initDone}};
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Shared ticks
  assign sampleTick = (sampleCnt == SAMPLE_CYCLES - 1);
  assign rampTick = (rampCnt == RAMP_CYCLES - 1);
  always_ff @(posedge clock) begin
    if (!sysRstN) begin
      sampleCnt <= 32'h00000000;
      rampCnt <= 32'h00000000;
    end else begin
      sampleCnt <= sampleTick ? 32'h00000000 : sampleCnt + 32'h00000001;
      rampCnt <= rampTick ? 32'h00000000 : rampCnt + 32'h00000001;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [1:0] pickInput(input logic [3:0] v);
    pickInput = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
  endfunction
  function automatic logic [4:0] clampBw(input logic [4:0] c,
                                         input logic [4:0] lo,
                                         input logic [4:0] hi);
    clampBw = (c < lo) ? lo : (c > hi) ? hi : c;
  endfunction
  //////////////////////////////////////////////////////////////////////
  // Per-loop mode control
  for (genvar gl = 0; gl < `PMC_NLOOP; gl++) begin : gLoop
    localparam int B = `PMC_LOOP_BASE + gl * `PMC_LOOP_STRIDE;
    pmc_pkg::pmc_mode_t mode;
    logic [31:0] aCfg;
    logic [23:0] aNom;
    logic [4:0] normBw;
    logic [4:0] fastBw;
    logic [4:0] exitBw;
    logic [3:0] avail;
    logic [1:0] selIdx;
    logic exitPull;
    logic enterHold;
    logic rampGo;
    logic cmdWr;
    logic stepUp;
    logic stepDown;
    logic apply;
    logic [5:0] rate;
    logic [23:0] rampStep;
    logic [23:0] holdFreq;
    logic holdValid;
    logic [23:0] rampFreq;
    logic rampBusy;
    logic [23:0] baseReg;
    logic [23:0] dcoOff;
    logic [23:0] freqReg;
    logic [4:0] bwReg;
    logic [31:0] freq_step_word;
    logic [31:0] hwin;
    assign freq_step_word = regMem[B + `PMC_R_FSW];
    assign hwin = regMem[B + `PMC_R_HWIN];
    assign cmdWr = wrEn && busIdx == 6'(B) + 6'(`PMC_R_CMD);
    assign apply = applyAll || (cmdWr && busWrData[`PMC_CMD_LIVE]);
    assign avail = validSync & aCfg[`PMC_CFG_MASK_LO +: 4];
    assign stepUp = aCfg[`PMC_CFG_DCO] && ((cmdWr &&
                    busWrData[`PMC_CMD_UP]) ||
                    (aCfg[`PMC_CFG_PINSTEP] && upPinEdge));
    assign stepDown = aCfg[`PMC_CFG_DCO] && ((cmdWr &&
                      busWrData[`PMC_CMD_DOWN]) ||
                      (aCfg[`PMC_CFG_PINSTEP] && downPinEdge));
    assign rate = (regMem[B + `PMC_R_RAMP][5:0] > `PMC_RAMP_MAX) ?
                  `PMC_RAMP_MAX : regMem[B + `PMC_R_RAMP][5:0];
    assign rampStep = (rate[0] ? 24'h000003 : 24'h000002)
                      << rate[5:1];
    assign modeBits[gl] = mode;
    assign freqWord[gl] = freqReg;
    assign bandwidthSel[gl] = bwReg;
    // Config, nominal frequency and bandwidths take effect only on apply, so other loops stay put
    always_ff @(posedge clock) begin
      if (!sysRstN) begin
        aCfg <= 32'h00000000;
        aNom <= 24'h000000;
        normBw <= 5'h00;
        fastBw <= `PMC_BW_FAST_MIN;
        exitBw <= 5'h00;
      end else if (apply) begin
        aCfg <= regMem[B + `PMC_R_LCFG];
        aNom <= regMem[B + `PMC_R_FREQ][23:0];
        normBw <= clampBw(regMem[B + `PMC_R_BW][`PMC_BW_NORM_LO +: 5],
                          5'h00, `PMC_BW_NORM_MAX);
        fastBw <= clampBw(regMem[B + `PMC_R_BW][`PMC_BW_FAST_LO +: 5],
                          `PMC_BW_FAST_MIN, `PMC_BW_FAST_MAX);
        exitBw <= clampBw(regMem[B + `PMC_R_BW][`PMC_BW_EXIT_LO +: 5],
                          5'h00, `PMC_BW_NORM_MAX);
      end
    end
    // Mode state machine
    always_ff @(posedge clock) begin
      if (!sysRstN || !initDone) begin
        mode <= pmc_pkg::PMC_FREERUN;
        exitPull <= 1'b0;
        enterHold <= 1'b0;
        rampGo <= 1'b0;
        selIdx <= 2'h0;
      end else begin
        enterHold <= 1'b0;
        rampGo <= 1'b0;
        if (|avail) begin
          selIdx <= pickInput(avail);
        end
        case (mode)
          pmc_pkg::PMC_FREERUN: begin
            if (|avail) begin
              mode <= pmc_pkg::PMC_ACQUIRE;
            end
          end
          pmc_pkg::PMC_ACQUIRE: begin
            if (!(|avail)) begin
              mode <= pmc_pkg::PMC_HOLDOVER;
              enterHold <= 1'b1;
            end else if (!lolSync[gl] && !rampBusy && !rampGo) begin
              mode <= pmc_pkg::PMC_LOCKED;
              exitPull <= 1'b0;
            end
          end
          pmc_pkg::PMC_LOCKED: begin
            if (!(|avail)) begin
              mode <= pmc_pkg::PMC_HOLDOVER;
              enterHold <= 1'b1;
            end else if (lolSync[gl]) begin
              mode <= pmc_pkg::PMC_ACQUIRE;
            end else if (pickInput(avail) != selIdx &&
                         aCfg[`PMC_CFG_RAMPSW]) begin
              rampGo <= 1'b1;
            end
          end
          pmc_pkg::PMC_HOLDOVER: begin
            if (|avail) begin
              mode <= pmc_pkg::PMC_ACQUIRE;
              rampGo <= aCfg[`PMC_CFG_RAMPEXIT];
              exitPull <= !aCfg[`PMC_CFG_RAMPEXIT];
            end
          end
          default: begin
            mode <= pmc_pkg::PMC_FREERUN;
          end
        endcase
      end
    end
    pmc_holdover uHold (
      .clock(clock),
      .rst_n(sysRstN),
      .sampleTick(sampleTick),
      .rampTick(rampTick),
      .record(mode == pmc_pkg::PMC_LOCKED),
      .calcStart(enterHold),
      .winLog(hwin[`PMC_WIN_LO +: 3]),
      .winDelay(hwin[`PMC_DLY_LO +: 7]),
      .sampleIn(trackFreq[gl]),
      .rampStart(rampGo),
      .rampFrom(baseReg),
      .rampTo(trackFreq[gl]),
      .rampStep(rampStep),
      .holdFreq(holdFreq),
      .holdValid(holdValid),
      .rampFreq(rampFreq),
      .rampBusy(rampBusy)
    );
    // Frequency and bandwidth outputs
    always_ff @(posedge clock) begin
      if (!sysRstN) begin
        baseReg <= 24'h000000;
        dcoOff <= 24'h000000;
        freqReg <= 24'h000000;
        bwReg <= 5'h00;
        lossOfLockPinN[gl] <= 1'b0;
      end else begin
        case (mode)
          pmc_pkg::PMC_FREERUN: baseReg <= aNom;
          pmc_pkg::PMC_HOLDOVER: begin
            if (holdValid) begin
              baseReg <= holdFreq;
            end
          end
          default: begin
            if (rampBusy) begin
              baseReg <= rampFreq;
            end else if (!rampGo) begin
              baseReg <= trackFreq[gl];
            end
          end
        endcase
        if (!aCfg[`PMC_CFG_DCO]) begin
          dcoOff <= 24'h000000;
        end else if (stepUp) begin
          dcoOff <= dcoOff + freq_step_word[23:0];
        end else if (stepDown) begin
          dcoOff <= dcoOff - freq_step_word[23:0];
        end
        freqReg <= baseReg + dcoOff;
        if (exitPull) begin
          bwReg <= aCfg[`PMC_CFG_EXITBW] ? exitBw :
                   aCfg[`PMC_CFG_PULLFAST] ? fastBw : normBw;
        end else if (mode == pmc_pkg::PMC_ACQUIRE &&
                     aCfg[`PMC_CFG_FAST]) begin
          bwReg <= fastBw;
        end else begin
          bwReg <= normBw;
        end
        lossOfLockPinN[gl] <= (mode == pmc_pkg::PMC_LOCKED);
      end
    end
  end
endmodule // pmc_top

//--- testbench/pmc_top_monitor.sv
`timescale 1ns/1ps
module pmc_top_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hardResetPinN,
  input wire logic [3:0] inputValid,
  input wire logic [3:0] lossOfLockRaw,
  input wire logic [7:0] busAddr,
  input wire logic [31:0] busWrData,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic [31:0] busRdData,
  input wire logic busReady,
  input wire logic [3:0] clockOutEnable,
  input wire logic [3:0] lossOfLockPinN
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence sHardWr;
    busReady && busWrite && busAddr[7:2] == 6'h00 && busWrData[0];
  endsequence
  sequence sSoftWr;
    busReady && busWrite && busAddr[7:2] == 6'h00 && busWrData[1:0] == 2'b10;
  endsequence
  sequence sQuiet;
    (hardResetPinN && !(busWrite && busWrData[0])) [*3];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_CLK_OFF: assert property (!busReady |-> clockOutEnable == 4'h0)
    else $error("output clocks run before init done");
  AST_RD_IDLE: assert property (!busRead |=> busRdData == 32'h0)
    else $error("read data without a read");
  AST_CLOSED: assert property
    (busRead && !busReady |=> busRdData == 32'h0)
    else $error("bus answered during init");
  AST_HARD_BIT: assert property (sHardWr |-> ##[2:3] !busReady)
    else $error("hard reset bit ignored");
  AST_PIN_RST: assert property ((!hardResetPinN) [*3] |=> !busReady)
    else $error("hard reset pin ignored");
  AST_SOFT_KEEP: assert property (sQuiet ##0 sSoftWr |=> busReady)
    else $error("soft reset reran init");
  AST_LOL_LOST: assert property
    (lossOfLockRaw[0] [*6] |-> !lossOfLockPinN[0])
    else $error("locked while lock lost");
  AST_NO_INPUT: assert property
    ((inputValid == 4'h0) [*6] |-> lossOfLockPinN == 4'h0)
    else $error("locked without input");
endmodule // pmc_top_monitor

bind pmc_top pmc_top_monitor pmc_top_monitor_i (
  .clock(clock),
  .rst_n(rst_n),
  .hardResetPinN(hardResetPinN),
  .inputValid(inputValid),
  .lossOfLockRaw(lossOfLockRaw),
  .busAddr(busAddr),
  .busWrData(busWrData),
  .busWrite(busWrite),
  .busRead(busRead),
  .busRdData(busRdData),
  .busReady(busReady),
  .clockOutEnable(clockOutEnable),
  .lossOfLockPinN(lossOfLockPinN)
);

//--- testbench/pmc_nvm_model.sv
`timescale 1ns/1ps
module pmc_nvm_model (
  input wire logic clock,
  input wire logic [5:0] nvmAddr,
  output logic [31:0] nvmRdData
);
  // Loop l listens to input l; loop 0 uses exit bandwidth
  function automatic logic [31:0] image(input logic [5:0] a);
    logic [1:0] l;
    l = 2'(a[5:3] - 3'h1);
    if (a < 6'h08) return 32'h0;
    case (a[2:0])
      3'h0: return (32'h100 << l) | (l == 2'h0 ? 32'h9 : 32'h1);
      3'h1: return 32'h00051002;
      3'h5: return 32'h00100000;
      default: return 32'h0;
    endcase
  endfunction
  always_ff @(posedge clock) begin
    nvmRdData <= image(nvmAddr);
  end
endmodule // pmc_nvm_model

//--- testbench/pmc_top_tb.sv
`timescale 1ns/1ps
module pmc_top_tb;
  logic clock, rst_n, hardResetPinN, freqStepUpPin, freqStepDownPin;
  logic busWrite, busRead, busReady;
  logic [3:0] inputValid, lossOfLockRaw, clockOutEnable, lossOfLockPinN;
  logic [3:0][23:0] trackFreq, freqWord;
  logic [3:0][4:0] bandwidthSel;
  logic [5:0] nvmAddr;
  logic [31:0] nvmRdData, busWrData, busRdData, rdVal;
  logic [7:0] busAddr;
  int err_count = 0;
  int check_count = 0;
  int cycCount = 0;
  pmc_top #(.SAMPLE_CYCLES(50), .RAMP_CYCLES(5)) pmc_top_i (
    .clock(clock), .rst_n(rst_n), .hardResetPinN(hardResetPinN),
    .inputValid(inputValid), .lossOfLockRaw(lossOfLockRaw),
    .freqStepUpPin(freqStepUpPin), .freqStepDownPin(freqStepDownPin),
    .trackFreq(trackFreq), .nvmAddr(nvmAddr), .nvmRdData(nvmRdData),
    .busAddr(busAddr), .busWrData(busWrData), .busWrite(busWrite),
    .busRead(busRead), .busRdData(busRdData), .busReady(busReady),
    .clockOutEnable(clockOutEnable), .lossOfLockPinN(lossOfLockPinN),
    .freqWord(freqWord), .bandwidthSel(bandwidthSel)
  );
  pmc_nvm_model pmc_nvm_model_i (
    .clock(clock), .nvmAddr(nvmAddr), .nvmRdData(nvmRdData)
  );
  always #5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    @(posedge clock);
    busWrite <= 1'b1;
    busAddr <= {idx, 2'b00};
    busWrData <= d;
    @(posedge clock);
    busWrite <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] idx, output logic [31:0] d);
    @(posedge clock);
    busRead <= 1'b1;
    busAddr <= {idx, 2'b00};
    @(posedge clock);
    busRead <= 1'b0;
    #1 d = busRdData;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (busReady !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk("ready", {31'h0, busReady}, 32'h1);
  endtask
  task automatic chk_mode(input int l, input logic [1:0] m);
    rd(6'(15 + 8 * l), rdVal);
    chk("mode", {30'h0, rdVal[1:0]}, {30'h0, m});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_init();
    chk("clk off", {28'h0, clockOutEnable}, 32'h0);
    rd(6'h01, rdVal);
    chk("early read", rdVal, 32'h0);
    wait_ready();
    chk("clk on", {28'h0, clockOutEnable}, 32'hF);
    chk("nvm end", 32'(nvmAddr), 32'h28);
    rd(6'h01, rdVal);
    chk("status", rdVal & 32'hFFF1, 32'h1);
    rd(6'h02, rdVal);
    chk("unmapped", rdVal, 32'h0);
    $display("test_init done");
  endtask
  task automatic test_lock();
    inputValid <= 4'h1;
    cyc(6);
    chk_mode(0, pmc_pkg::PMC_ACQUIRE);
    chk("fast bw", 32'(bandwidthSel[0]), 32'h10);
    chk_mode(1, pmc_pkg::PMC_FREERUN);
    lossOfLockRaw <= 4'hE;
    cyc(8);
    chk_mode(0, pmc_pkg::PMC_LOCKED);
    chk("pin", {28'h0, lossOfLockPinN}, 32'h1);
    chk("norm bw", 32'(bandwidthSel[0]), 32'h02);
    lossOfLockRaw <= 4'hF;
    cyc(8);
    chk_mode(0, pmc_pkg::PMC_ACQUIRE);
    chk("pin lost", {28'h0, lossOfLockPinN}, 32'h0);
    lossOfLockRaw <= 4'hE;
    cyc(8);
    $display("test_lock done");
  endtask
  task automatic test_hold();
    trackFreq[0] <= 24'h123450;
    wr(6'h0B, 32'h100);
    cyc(400);
    trackFreq[0] <= 24'h123456;
    inputValid <= 4'h0;
    cyc(6);
    chk_mode(0, pmc_pkg::PMC_HOLDOVER);
    cyc(20);
    chk("hold freq", 32'(freqWord[0]), 32'h123450);
    lossOfLockRaw <= 4'hF;
    trackFreq[0] <= 24'h123460;
    inputValid <= 4'h1;
    cyc(6);
    chk_mode(0, pmc_pkg::PMC_ACQUIRE);
    chk("exit bw", 32'(bandwidthSel[0]), 32'h05);
    lossOfLockRaw <= 4'hE;
    cyc(8);
    chk_mode(0, pmc_pkg::PMC_LOCKED);
    chk("relock bw", 32'(bandwidthSel[0]), 32'h02);
    wr(6'h08, 32'h10D);
    wr(6'h0E, 32'h4);
    inputValid <= 4'h0;
    cyc(30);
    trackFreq[0] <= 24'h123500;
    inputValid <= 4'h1;
    cyc(40);
    chk_mode(0, pmc_pkg::PMC_ACQUIRE);
    chk("ramping", 32'(freqWord[0] != 24'h123500), 32'h1);
    cyc(600);
    chk_mode(0, pmc_pkg::PMC_LOCKED);
    chk("ramp end", 32'(freqWord[0]), 32'h123500);
    $display("test_hold done");
  endtask
  task automatic test_osc();
    chk("free freq", 32'(freqWord[1]), 32'h100000);
    wr(6'h10, 32'h50);
    wr(6'h14, 32'h10);
    wr(6'h15, 32'h200000);
    cyc(3);
    chk("pending", 32'(freqWord[1]), 32'h100000);
    wr(6'h16, 32'h4);
    cyc(4);
    chk("applied", 32'(freqWord[1]), 32'h200000);
    chk_mode(0, pmc_pkg::PMC_LOCKED);
    wr(6'h16, 32'h1);
    cyc(3);
    chk("step up", 32'(freqWord[1]), 32'h200010);
    wr(6'h16, 32'h2);
    wr(6'h16, 32'h2);
    cyc(3);
    chk("step down", 32'(freqWord[1]), 32'h1FFFF0);
    freqStepUpPin <= 1'b1;
    cyc(6);
    chk("pin up", 32'(freqWord[1]), 32'h200000);
    freqStepUpPin <= 1'b0;
    freqStepDownPin <= 1'b1;
    cyc(6);
    chk("pin down", 32'(freqWord[1]), 32'h1FFFF0);
    freqStepDownPin <= 1'b0;
    $display("test_osc done");
  endtask
  task automatic test_reset();
    wr(6'h1A, 32'h5);
    wr(6'h15, 32'h300000);
    wr(6'h00, 32'h2);
    cyc(3);
    chk("soft ready", {31'h0, busReady}, 32'h1);
    chk("soft apply", 32'(freqWord[1]), 32'h2FFFF0);
    rd(6'h1A, rdVal);
    chk("soft kept", rdVal, 32'h5);
    wr(6'h00, 32'h1);
    cyc(3);
    chk("hard down", {31'h0, busReady}, 32'h0);
    wait_ready();
    rd(6'h1A, rdVal);
    chk("reloaded", rdVal, 32'h0);
    rd(6'h15, rdVal);
    chk("nvm freq", rdVal, 32'h100000);
    hardResetPinN <= 1'b0;
    cyc(4);
    hardResetPinN <= 1'b1;
    cyc(1);
    chk("pin down", {31'h0, busReady}, 32'h0);
    wait_ready();
    chk("clk back", {28'h0, clockOutEnable}, 32'hF);
    $display("test_reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    hardResetPinN = 1'b1;
    inputValid = 4'h0;
    lossOfLockRaw = 4'hF;
    freqStepUpPin = 1'b0;
    freqStepDownPin = 1'b0;
    trackFreq = '0;
    trackFreq[0] = 24'h123456;
    busAddr = 8'h00;
    busWrData = 32'h0;
    busWrite = 1'b0;
    busRead = 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    test_init();
    test_lock();
    test_hold();
    test_osc();
    test_reset();
    stop_test();
  end
  always @(posedge clock) begin
    cycCount++;
    if (cycCount == 20000) begin
      err_count++;
      $display("timeout reached");
      stop_test();
    end
  end
endmodule // pmc_top_tb
